/* verilog/ppfc_regs.vh */
// Purpose: Constants for the two-bit port pin function control
// Assumes: Included by the port pin function control design files
// Notes:   Definitions only
`ifndef PPFC_REGS_VH
`define PPFC_REGS_VH

// Port width
`define PPFC_PORT_W        2

// Output-type encodings, one per pin
`define PPFC_MODE_QUASI    2'h0
`define PPFC_MODE_PUSH     2'h1
`define PPFC_MODE_INPUT    2'h2
`define PPFC_MODE_OPEN     2'h3
`define PPFC_MODE_RST      2'h2

// CPU clock source encodings
`define PPFC_SRC_RC        2'h0
`define PPFC_SRC_WDOG      2'h1
`define PPFC_SRC_EXT       2'h2
`define PPFC_SRC_XTAL      2'h3

// Reset values
`define PPFC_LATCH_RST     2'h3
`define PPFC_PULL_RST      2'h0

// Readback word field positions
`define PPFC_RB_LATCH_LSB  0
`define PPFC_RB_AMP_BIT    2
`define PPFC_RB_CLKO_BIT   3
`define PPFC_RB_ZERO_BIT   4
`define PPFC_RB_ONE_BIT    5
`define PPFC_RB_RSVD_LSB   6

// Fixed and reserved bit values on read
`define PPFC_RB_ZERO_VAL   1'h0
`define PPFC_RB_ONE_VAL    1'h1
`define PPFC_RB_RSVD_VAL   2'h0

// Pin synchroniser depth
`define PPFC_SYNC_STAGES   3

`endif

/* verilog/ppfc_sync.v */
// Purpose: Three-stage pin input synchroniser with agreement filter
// Assumes: One clock, clock enable freezes all state
// Notes:   First stage feeds only the second stage
`timescale 1ns/100ps
`default_nettype none

module ppfc_sync #(
   parameter W = 2
) (
   input  wire         clk,
   input  wire         rst,
   input  wire         ce,
   input  wire [W-1:0] din,
   output reg  [W-1:0] dout
);

   reg [W-1:0] s1_q;
   reg [W-1:0] s2_q;
   reg [W-1:0] s3_q;
   genvar      i;

   always @(posedge clk) begin
      if (rst) begin
         s1_q <= {W{1'b1}};
         s2_q <= {W{1'b1}};
         s3_q <= {W{1'b1}};
      end else if (ce) begin
         s1_q <= din;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // A change counts once stages two and three agree
   generate
      for (i = 0; i < W; i = i + 1) begin : g_flt
         always @(posedge clk) begin
            if (rst) begin
               dout[i] <= 1'b1;
            end else if (ce && (s2_q[i] == s3_q[i])) begin
               dout[i] <= s3_q[i];
            end
         end
      end
   endgenerate

endmodule // ppfc_sync

`default_nettype wire

/* verilog/ppfc_top.v */
// Purpose: Two-bit port with oscillator and clock-output pin functions
// Assumes: CPU clock is MCLK, synchronous active-high reset RST
// Notes:   Configuration arrives on plain inputs, no software bus
//
// Overview of operation
// - Reset makes both pins input-only, pull-ups off
// - Clock output drives CPU clock divided by two
// - Clock output only from RC, watchdog, external
// - Input pin is port only for RC/watchdog
// - Crystal option gives bit zero to amplifier
// - Reserved bits written zero, always read as zero
// - Fixed bits read back their fixed value
`timescale 1ns/100ps
`include "ppfc_regs.vh"
`default_nettype none

module ppfc_top #(
   parameter W = `PPFC_PORT_W
) (
   // Clock, reset, enable
   input  wire         MCLK,
   input  wire         RST,
   input  wire         CE,
   // Clock configuration
   input  wire [1:0]   CLK_SRC,
   input  wire         RTC_ON_XTAL,
   input  wire         CLOCK_OUTPUT_ENABLE,
   // Pin output-type configuration
   input  wire         MODE_WR,
   input  wire [2*W-1:0] MODE_WDATA,
   // Port latch access
   input  wire         PORT_WR,
   input  wire [W-1:0] PORT_WDATA,
   output reg  [W-1:0] PORT_RDATA,
   output reg  [7:0]   STATUS_RDATA,
   // Pins
   input  wire [W-1:0] PIN_I,
   output reg  [W-1:0] PIN_O,
   output reg  [W-1:0] PIN_OE,
   output reg  [W-1:0] PULLUP_EN,
   // Oscillator function selects
   output reg          OSC_AMP_OUTPUT_SEL,
   output reg          OSC_AMP_INPUT_SEL
);

   // Pin zero function states, one-hot
   localparam [2:0] FN_PORT = 3'h1;
   localparam [2:0] FN_CLKO = 3'h2;
   localparam [2:0] FN_AMP  = 3'h4;

   reg  [2*W-1:0] mode_q;
   reg  [W-1:0]   latch_q;
   reg            div_q;
   reg  [2:0]     fn0_q;
   reg  [2:0]     fn0_d;
   wire           clko_act_q;
   wire           amp_q;
   reg            oscin_q;
   wire [W-1:0]   pin_s;
   wire           src_int;
   wire           clko_ok;
   wire           amp_d;
   wire           oscin_d;
   wire           clko_d;
   wire [W-1:0]   special;
   reg  [W-1:0]   drv_o;
   reg  [W-1:0]   drv_oe;
   reg  [W-1:0]   drv_pu;
   genvar         i;

   // Pin input synchroniser
   ppfc_sync #(
      .W    (W)
   ) u_sync (
      .clk  (MCLK),
      .rst  (RST),
      .ce   (CE),
      .din  (PIN_I),
      .dout (pin_s)
   );

   // Function selection from clock configuration
   assign src_int = (CLK_SRC == `PPFC_SRC_RC) ||
                    (CLK_SRC == `PPFC_SRC_WDOG);
   assign amp_d   = (CLK_SRC == `PPFC_SRC_XTAL) || RTC_ON_XTAL;
   assign oscin_d = !(src_int && !RTC_ON_XTAL);
   assign clko_ok = (src_int || (CLK_SRC == `PPFC_SRC_EXT)) &&
                    !RTC_ON_XTAL;
   assign clko_d  = CLOCK_OUTPUT_ENABLE && clko_ok && !amp_d;
   assign special = {oscin_q, amp_q || clko_act_q};
   assign amp_q      = fn0_q[2];
   assign clko_act_q = fn0_q[1];

   // Pin zero function selection
   // Crystal use outranks the clock output request
   always @* begin
      fn0_d = fn0_q;
      case (fn0_q)
         FN_PORT: begin
            if (amp_d) begin
               fn0_d = FN_AMP;
            end else if (clko_d) begin
               fn0_d = FN_CLKO;
            end
         end
         FN_CLKO: begin
            if (amp_d) begin
               fn0_d = FN_AMP;
            end else if (!clko_d) begin
               fn0_d = FN_PORT;
            end
         end
         FN_AMP: begin
            if (!amp_d) begin
               fn0_d = clko_d ? FN_CLKO : FN_PORT;
            end
         end
         default: begin
            fn0_d = FN_PORT;
         end
      endcase
   end

   // Configuration and latch state
   always @(posedge MCLK) begin
      if (RST) begin
         mode_q     <= {W{`PPFC_MODE_RST}};
         latch_q    <= `PPFC_LATCH_RST;
         div_q      <= 1'b0;
         fn0_q      <= FN_PORT;
         oscin_q    <= 1'b0;
      end else if (CE) begin
         if (MODE_WR) begin
            mode_q <= MODE_WDATA;
         end
         if (PORT_WR) begin
            latch_q <= PORT_WDATA;
         end
         fn0_q      <= fn0_d;
         oscin_q    <= oscin_d;
         if (clko_d) begin
            div_q <= ~div_q;
         end else begin
            div_q <= 1'b0;
         end
      end
   end

   // Per-pin output type
   generate
      for (i = 0; i < W; i = i + 1) begin : g_pin
         wire [1:0] md;
         assign md = mode_q[2*i +: 2];

         always @* begin
            drv_o[i]  = latch_q[i];
            drv_oe[i] = 1'b0;
            drv_pu[i] = 1'b0;
            case (md)
               `PPFC_MODE_QUASI: begin
                  drv_oe[i] = ~latch_q[i];
                  drv_pu[i] = 1'b1;
               end
               `PPFC_MODE_PUSH: begin
                  drv_oe[i] = 1'b1;
               end
               `PPFC_MODE_OPEN: begin
                  drv_oe[i] = ~latch_q[i];
               end
               `PPFC_MODE_INPUT: begin
                  drv_oe[i] = 1'b0;
               end
               default: begin
                  drv_oe[i] = 1'b0;
               end
            endcase
         end
      end
   endgenerate

   // Pin drivers
   always @(posedge MCLK) begin
      if (RST) begin
         PIN_O              <= {W{1'b0}};
         PIN_OE             <= {W{1'b0}};
         PULLUP_EN          <= `PPFC_PULL_RST;
         OSC_AMP_OUTPUT_SEL <= 1'b0;
         OSC_AMP_INPUT_SEL  <= 1'b0;
      end else if (CE) begin
         PIN_O              <= drv_o;
         PIN_OE             <= drv_oe & ~special;
         PULLUP_EN          <= drv_pu & ~special;
         OSC_AMP_OUTPUT_SEL <= amp_q;
         OSC_AMP_INPUT_SEL  <= oscin_q;
         // Clock output overrides the port driver
         if (clko_act_q) begin
            PIN_O[0]  <= div_q;
            PIN_OE[0] <= 1'b1;
         end
      end
   end

   // Readback
   always @(posedge MCLK) begin
      if (RST) begin
         PORT_RDATA   <= {W{1'b1}};
         STATUS_RDATA <= 8'h20;
      end else if (CE) begin
         PORT_RDATA <= pin_s;
         STATUS_RDATA[`PPFC_RB_LATCH_LSB +: 2] <= latch_q;
         STATUS_RDATA[`PPFC_RB_AMP_BIT]  <= amp_q;
         STATUS_RDATA[`PPFC_RB_CLKO_BIT] <= clko_act_q;
         STATUS_RDATA[`PPFC_RB_ZERO_BIT] <= `PPFC_RB_ZERO_VAL;
         STATUS_RDATA[`PPFC_RB_ONE_BIT]  <= `PPFC_RB_ONE_VAL;
         STATUS_RDATA[`PPFC_RB_RSVD_LSB +: 2] <= `PPFC_RB_RSVD_VAL;
      end
   end

endmodule // ppfc_top

`default_nettype wire

/* dv/ppfc_top_asserts.sv */
// Purpose: Checker on the port pin function ports
// Assumes: Sees only the top module ports
// Notes:   Bind follows the module
`timescale 1ns/100ps
`default_nettype none
module ppfc_chk #(parameter W = 2) (
   // Clock and configuration
   input wire logic           MCLK,
   input wire logic           RST,
   input wire logic           CE,
   input wire logic [1:0]     CLK_SRC,
   input wire logic           RTC_ON_XTAL,
   input wire logic           CLOCK_OUTPUT_ENABLE,
   input wire logic           MODE_WR,
   input wire logic [2*W-1:0] MODE_WDATA,
   // Pin side
   input wire logic [7:0]     STATUS_RDATA,
   input wire logic [W-1:0]   PIN_O,
   input wire logic [W-1:0]   PIN_OE,
   input wire logic [W-1:0]   PULLUP_EN,
   input wire logic           OSC_AMP_OUTPUT_SEL,
   input wire logic           OSC_AMP_INPUT_SEL
);
   default clocking @(posedge MCLK); endclocking
   default disable iff (RST);
   wire logic ck = CE && CLOCK_OUTPUT_ENABLE && CLK_SRC != 2'h3 &&
                   !RTC_ON_XTAL;
   wire logic xt = CE && (CLK_SRC == 2'h3 || RTC_ON_XTAL);
   wire logic p1 = CE && !CLK_SRC[1] && !RTC_ON_XTAL;
   a_reset_state: assert property (
      $fell(RST) |-> PIN_OE == '0 && PULLUP_EN == '0) else $error("reset");
   a_fixed_bits: assert property (
      STATUS_RDATA[7:4] == 4'h2) else $error("fixed bits");
   a_clko_drive: assert property (
      ck[*4] |-> PIN_OE[0] && STATUS_RDATA[3]) else $error("clock out off");
   a_clko_toggle: assert property (
      ck[*4] |-> PIN_O[0] != $past(PIN_O[0])) else $error("no toggle");
   a_amp_output: assert property (
      xt[*3] |-> OSC_AMP_OUTPUT_SEL && !PIN_OE[0] && !STATUS_RDATA[3])
      else $error("amp output");
   a_pin1_release: assert property (
      (CE && !p1)[*3] |-> !PIN_OE[1] && !PULLUP_EN[1])
      else $error("pin1 drive");
   a_pin1_port: assert property (
      p1[*3] |-> !OSC_AMP_INPUT_SEL) else $error("pin1 port");
   a_mode_input: assert property (
      CE && MODE_WR && MODE_WDATA[3:2] == 2'h2 |-> ##2 !PIN_OE[1])
      else $error("input mode");
   c_clko: cover property (ck[*8]);
   c_xtal: cover property (xt[*4]);
   c_mode: cover property (CE && MODE_WR);
   c_pull: cover property (PULLUP_EN != '0);
endmodule // ppfc_chk
bind ppfc_top ppfc_chk #(.W(W)) u_ppfc_chk (.MCLK, .RST, .CE, .CLK_SRC,
   .RTC_ON_XTAL, .CLOCK_OUTPUT_ENABLE, .MODE_WR, .MODE_WDATA, .STATUS_RDATA,
   .PIN_O, .PIN_OE, .PULLUP_EN, .OSC_AMP_OUTPUT_SEL, .OSC_AMP_INPUT_SEL);
`default_nettype wire

/* dv/ppfc_board.sv */
// Purpose: Board model resolving the two port pins
// Assumes: Design drives a pin while its enable is high
// Notes:   Undriven pins without pull-up change every cycle
`timescale 1ns/100ps
`default_nettype none
module ppfc_board (
   // Clock
   input wire logic       clk,
   // Design side
   input wire logic [1:0] pin_o,
   input wire logic [1:0] pin_oe,
   input wire logic [1:0] pull_en,
   // Board drive
   input wire logic [1:0] ext_val,
   input wire logic [1:0] ext_en,
   // Resolved level
   output var logic [1:0] pin_lvl
);
   logic flt_q = 1'b0;
   always @(posedge clk) flt_q <= !flt_q;
   always @* begin
      for (int i = 0; i < 2; i++)
         pin_lvl[i] = pin_oe[i] ? pin_o[i] : ext_en[i] ? ext_val[i] :
            pull_en[i] ? 1'b1 : flt_q;
   end
endmodule // ppfc_board
`default_nettype wire

/* dv/tb_ppfc_top.sv */
// Purpose: Self-checking bench for the port pin function block
// Assumes: Inputs change on the falling edge
// Notes:   Rows cover every clock source with and without timer use
`timescale 1ns/100ps
`default_nettype none
module tb_ppfc_top;
   logic       mclk = 0, rst = 1, ce = 1, rtc = 0, clko_en = 0, b;
   logic       mode_wr = 0, port_wr = 0, amp_o, amp_i;
   logic [1:0] src = 0, port_wd = 0, ext_val = 0, ext_en = 0;
   logic [1:0] port_rd, pin_i, pin_o, pin_oe, pull;
   logic [3:0] mode_wd = 0;
   logic [7:0] status;
   logic [5:0] r;
   int         miscompares = 0, compares = 0, n;
   // Source, timer use, then clock out, amp output, pin 1 select
   logic [5:0] rows [8] = '{6'h04, 6'h14, 6'h25, 6'h33,
                            6'h0b, 6'h1b, 6'h2b, 6'h3b};
   ppfc_top u_ppfc_top (.MCLK(mclk), .RST(rst), .CE(ce), .CLK_SRC(src),
      .RTC_ON_XTAL(rtc), .CLOCK_OUTPUT_ENABLE(clko_en), .MODE_WR(mode_wr),
      .MODE_WDATA(mode_wd), .PORT_WR(port_wr), .PORT_WDATA(port_wd),
      .PORT_RDATA(port_rd), .STATUS_RDATA(status), .PIN_I(pin_i),
      .PIN_O(pin_o), .PIN_OE(pin_oe), .PULLUP_EN(pull),
      .OSC_AMP_OUTPUT_SEL(amp_o), .OSC_AMP_INPUT_SEL(amp_i));
   ppfc_board u_ppfc_board (.clk(mclk), .pin_o(pin_o), .pin_oe(pin_oe),
      .pull_en(pull), .ext_val(ext_val), .ext_en(ext_en), .pin_lvl(pin_i));
   initial forever #12.5 mclk = !mclk;
   task cyc(input int k);
      repeat (k) @(negedge mclk);
   endtask
   task wr_cfg(input logic [3:0] m, input logic [1:0] d);
      {mode_wd, port_wd} = {m, d};
      {mode_wr, port_wr} = 2'h3;
      cyc(1);
      {mode_wr, port_wr} = 2'h0;
      cyc(2);
   endtask
   task chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task give_verdict;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      cyc(12);
      chk({pin_oe, pull, port_rd, status[5:4]}, 8'h0e);
      rst = 0;
      clko_en = 1;
      foreach (rows[i]) begin
         r = rows[i];
         {src, rtc} = r[5:3];
         cyc(4);
         chk({status[3], amp_o, amp_i, pin_oe[0]}, {r[2:0], r[2]});
      end
      {src, rtc} = 3'h0;
      cyc(4);
      n = 0;
      repeat (8) begin
         b = pin_o[0];
         cyc(1);
         n += (pin_o[0] != b);
      end
      chk(n[7:0], 8'h08);
      ce = 0;
      {mode_wd, mode_wr} = 5'h0b;
      b = pin_o[0];
      cyc(3);
      mode_wr = 0;
      chk({pin_o[0], status[3]}, {b, 1'b1});
      ce = 1;
      cyc(3);
      chk(pin_oe, 8'h01);
      clko_en = 0;
      mode_wd = 4'ha;
      mode_wr = 1;
      {ext_en, ext_val} = 4'hd;
      cyc(1);
      mode_wr = 0;
      cyc(8);
      chk(port_rd, 8'h01);
      ext_val = 2'h2;
      cyc(8);
      chk(port_rd, 8'h02);
      {ext_en, mode_wd, port_wd} = 8'ha6;
      {mode_wr, port_wr} = 2'h3;
      cyc(1);
      {mode_wr, port_wr} = 2'h0;
      cyc(3);
      chk({pin_oe, pin_o[0]}, 8'h02);
      port_wd = 2'h3;
      port_wr = 1;
      cyc(1);
      port_wr = 0;
      cyc(3);
      chk({pin_oe, pin_o[0]}, 8'h03);
      wr_cfg(4'h0, 2'h1);
      chk({pin_oe, pull, pin_o}, 8'h2d);
      wr_cfg(4'h4, 2'h3);
      chk({pin_oe, pull, pin_o}, 8'h27);
      wr_cfg(4'he, 2'h0);
      chk({pin_oe, pull, pin_o}, 8'h20);
      wr_cfg(4'hf, 2'h2);
      chk({pin_oe, pull, pin_o}, 8'h12);
      src = 2'h3;
      cyc(4);
      chk({pin_oe, amp_o}, 8'h01);
      wr_cfg(4'h0, 2'h0);
      chk({pin_oe, pull}, 8'h00);
      rst = 1;
      cyc(2);
      chk({pin_oe, pull}, 8'h00);
      rst = 0;
      cyc(2);
      chk(status[7:4], 8'h02);
      give_verdict;
   end
endmodule // tb_ppfc_top
`default_nettype wire
